// >>> logic/pffp_pkg.sv
// Shared constants and types of the parallel flash programming port.
package pffp_pkg;

    // Transfer type codes steering a latched word
    localparam logic [3:0] PFFP_TYPE_CMD = 4'h0;
    localparam logic [3:0] PFFP_TYPE_ADDR_LO = 4'h1;
    localparam logic [3:0] PFFP_TYPE_ADDR_HI = 4'h2;
    localparam logic [3:0] PFFP_TYPE_DATA = 4'h5;

    // Command codes carried on the data lines
    localparam logic [15:0] PFFP_CMD_READ = 16'h0011;
    localparam logic [15:0] PFFP_CMD_WRITE_PAGE = 16'h0012;
    localparam logic [15:0] PFFP_CMD_WRITE_PAGE_THEN_LOCK = 16'h0022;
    localparam logic [15:0] PFFP_CMD_ERASE_THEN_WRITE_PAGE = 16'h0032;
    localparam logic [15:0] PFFP_CMD_ERASE_WRITE_THEN_LOCK = 16'h0042;
    localparam logic [15:0] PFFP_CMD_ERASE_WHOLE_FLASH = 16'h0013;
    localparam logic [15:0] PFFP_CMD_SET_LOCK_BITS = 16'h0014;
    localparam logic [15:0] PFFP_CMD_CLEAR_LOCK_BITS = 16'h0024;
    localparam logic [15:0] PFFP_CMD_GET_LOCK_BITS = 16'h0015;
    localparam logic [15:0] PFFP_CMD_SET_USER_NV_BITS = 16'h0034;
    localparam logic [15:0] PFFP_CMD_CLEAR_USER_NV_BITS = 16'h0044;
    localparam logic [15:0] PFFP_CMD_GET_USER_NV_BITS = 16'h0025;
    localparam logic [15:0] PFFP_CMD_SELECT_FLASH_CONTROLLER = 16'h0016;

    // Values after reset, and the address step
    localparam logic [15:0] PFFP_CMD_RESET = 16'h0000;
    localparam logic [31:0] PFFP_ADDR_RESET = 32'h0000_0000;
    localparam logic [15:0] PFFP_DATA_RESET = 16'h0000;
    localparam logic [31:0] PFFP_ADDR_STEP = 32'h0000_0001;

    // Final start-up count; ready is first driven after four cycles in start-up
    localparam logic [3:0] PFFP_INIT_CYCLES = 4'h3;

    // Operation handed to the flash side
    typedef enum logic [3:0]
    {
        PFFP_OP_NONE = 4'h0,
        PFFP_OP_READ = 4'h1,
        PFFP_OP_WRITE_PAGE = 4'h2,
        PFFP_OP_WRITE_PAGE_LOCK = 4'h3,
        PFFP_OP_ERASE_WRITE = 4'h4,
        PFFP_OP_ERASE_WRITE_LOCK = 4'h5,
        PFFP_OP_ERASE_ALL = 4'h6,
        PFFP_OP_SET_LOCK = 4'h7,
        PFFP_OP_CLEAR_LOCK = 4'h8,
        PFFP_OP_GET_LOCK = 4'h9,
        PFFP_OP_SET_NV = 4'ha,
        PFFP_OP_CLEAR_NV = 4'hb,
        PFFP_OP_GET_NV = 4'hc,
        PFFP_OP_SELECT_CTRL = 4'hd,
        PFFP_OP_FLUSH = 4'he
    } pffp_op_e;

    // Handshake sequencer states
    typedef enum logic [3:0]
    {
        PFFP_ST_INIT = 4'h0,
        PFFP_ST_IDLE = 4'h1,
        PFFP_ST_DISPATCH = 4'h2,
        PFFP_ST_FLUSH = 4'h3,
        PFFP_ST_EXEC = 4'h4,
        PFFP_ST_WAIT_OE_LOW = 4'h5,
        PFFP_ST_DRIVE = 4'h6,
        PFFP_ST_WAIT_OE_HIGH = 4'h7,
        PFFP_ST_WAIT_STROBE_HIGH = 4'h8
    } pffp_state_e;

endpackage : pffp_pkg

// >>> logic/pffp_dec_if.sv
// Carrier between the handshake sequencer and the command decoder.
`timescale 1ns/100ps
interface pffp_dec_if;
    import pffp_pkg::*;
    logic [15:0] cmd_word; // Stored pending command
    pffp_op_e op; // Operation a data transfer starts
    logic reads_back; // Data transfer is a read handshake
    logic page_write; // Data transfer fills the page load buffer
    logic auto_inc; // Address steps after each data word
    modport decoder (input cmd_word, output op, reads_back, page_write, auto_inc);
    modport user (output cmd_word, input op, reads_back, page_write, auto_inc);
endinterface : pffp_dec_if

// >>> logic/pffp_cmd_decode.sv
// Command word decoder of the parallel flash programming port.
`timescale 1ns/100ps
module pffp_cmd_decode
    import pffp_pkg::*;
#(
    parameter bit DUAL_CTRL = 1'b0 // Variant with two flash controllers
)
(
    pffp_dec_if.decoder dec
);

    // Maps a command code onto a flash operation
    function automatic pffp_op_e decode_op(input logic [15:0] code, input bit dual);
        pffp_op_e op;
        op = PFFP_OP_NONE;
        case (code)
            PFFP_CMD_READ: op = PFFP_OP_READ;
            PFFP_CMD_WRITE_PAGE: op = PFFP_OP_WRITE_PAGE;
            PFFP_CMD_WRITE_PAGE_THEN_LOCK: op = PFFP_OP_WRITE_PAGE_LOCK;
            PFFP_CMD_ERASE_THEN_WRITE_PAGE: op = PFFP_OP_ERASE_WRITE;
            PFFP_CMD_ERASE_WRITE_THEN_LOCK: op = PFFP_OP_ERASE_WRITE_LOCK;
            PFFP_CMD_ERASE_WHOLE_FLASH: op = PFFP_OP_ERASE_ALL;
            PFFP_CMD_SET_LOCK_BITS: op = PFFP_OP_SET_LOCK;
            PFFP_CMD_CLEAR_LOCK_BITS: op = PFFP_OP_CLEAR_LOCK;
            PFFP_CMD_GET_LOCK_BITS: op = PFFP_OP_GET_LOCK;
            PFFP_CMD_SET_USER_NV_BITS: op = PFFP_OP_SET_NV;
            PFFP_CMD_CLEAR_USER_NV_BITS: op = PFFP_OP_CLEAR_NV;
            PFFP_CMD_GET_USER_NV_BITS: op = PFFP_OP_GET_NV;
            // Only meaningful when a second controller exists
            PFFP_CMD_SELECT_FLASH_CONTROLLER: op = dual ? PFFP_OP_SELECT_CTRL : PFFP_OP_NONE;
            default: op = PFFP_OP_NONE;
        endcase
        return op;
    endfunction : decode_op

    // Decoded operation and the handshake flavour it implies
    assign dec.op = decode_op(dec.cmd_word, DUAL_CTRL);
    assign dec.reads_back = (dec.op == PFFP_OP_READ) || (dec.op == PFFP_OP_GET_LOCK) || (dec.op == PFFP_OP_GET_NV);
    assign dec.page_write = (dec.op == PFFP_OP_WRITE_PAGE) || (dec.op == PFFP_OP_WRITE_PAGE_LOCK) ||
                            (dec.op == PFFP_OP_ERASE_WRITE) || (dec.op == PFFP_OP_ERASE_WRITE_LOCK);
    // Reads and page writes walk the address; mask commands do not
    assign dec.auto_inc = dec.page_write || (dec.op == PFFP_OP_READ);

endmodule : pffp_cmd_decode

// >>> logic/pffp_port.sv
// Handshake sequencer of the parallel flash programming port.
`timescale 1ns/100ps

module pffp_port
    import pffp_pkg::*;
#(
    parameter bit DUAL_CTRL = 1'b0, // Variant with two flash controllers
    parameter int ADDR_W = 32 // Internal address width
)
(
    input wire logic core_clk_in, // Core clock, 100 MHz
    input wire logic resetn_in, // Asynchronous reset, active low
    // Programmer pins
    input wire logic command_strobe_n_in, // Command strobe, active low
    input wire logic output_enable_n_in, // Read output enable, active low
    input wire logic [3:0] transfer_type_in, // Type field of the transfer
    input wire logic [15:0] data_in, // Data bus, input side
    output logic [15:0] data_out, // Data bus, output side
    output logic data_oe_out, // Data bus output enable
    output logic ready_out, // Ready level
    output logic ready_oe_out, // Ready pin output enable
    output logic bus_driven_n_out, // Bus driven indication, active low
    output logic bus_driven_oe_out, // Bus driven pin output enable
    output logic handshake_pullup_out, // Pull-ups on the handshake pins
    output logic gpio_hold_input_out, // Unused pins held as pulled-up inputs
    output logic osc_bypass_out, // Crystal oscillator bypass
    // Clock selection
    input wire logic ext_clock_present_in, // External clock above threshold
    output logic clock_select_ext_out, // Core switched to the external clock
    // Flash side
    output logic flash_req_out, // Request, held until acknowledged
    output pffp_op_e flash_op_out, // Operation requested
    output logic [ADDR_W-1:0] flash_addr_out, // Address of the operation
    output logic [15:0] flash_wdata_out, // Write data or bit mask
    input wire logic flash_ack_in, // Operation finished, one cycle
    input wire logic [15:0] flash_rdata_in, // Read data valid with the ack
    output logic [15:0] command_out // Pending command word
);

    // Width of the bundle of pins brought into the clock domain
    localparam int SYNC_W = 23;

    pffp_dec_if dec (); // Carrier to the decoder

    logic [SYNC_W-1:0] pin_meta; // First synchroniser stage
    logic [SYNC_W-1:0] pin_sync; // Second synchroniser stage
    logic strobe_low; // Strobe seen low after sync
    logic oe_low; // Output enable seen low after sync
    logic ext_present; // External clock present after sync
    logic [3:0] type_sync; // Type field after sync
    logic [15:0] data_sync; // Data lines after sync

    pffp_state_e state; // Sequencer state
    pffp_state_e next_state; // Sequencer next state
    logic [3:0] init_count; // Start-up wait counter
    logic [3:0] latched_type; // Type of the current transfer
    logic [15:0] latched_data; // Data of the current transfer
    logic [15:0] cmd_reg; // Pending command
    logic [ADDR_W-1:0] addr_reg; // Internal address
    logic [15:0] read_data; // Word presented on a read
    logic page_pending; // Load buffer holds unflushed data
    logic ready; // Ready level
    logic pins_active; // Ready and bus-driven pins driven
    logic bus_drive; // Data bus driven
    logic bus_valid_n; // Bus driven indication
    logic clk_ext; // External clock selected
    logic req; // Flash request
    pffp_op_e req_op; // Flash operation
    logic [15:0] wdata; // Flash write data

    // Named decodes of the dispatch step
    logic is_cmd;
    logic is_addr_lo;
    logic is_addr_hi;
    logic is_data;
    logic data_has_op;

    // Two flops on every pin the programmer drives, first stage read only by the second
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pin_meta <= '1; // Pulled-up pins idle high
            pin_sync <= '1;
        end
        else
        begin
            pin_meta <= {command_strobe_n_in, output_enable_n_in, ext_clock_present_in,
                         transfer_type_in, data_in};
            pin_sync <= pin_meta;
        end
    end

    // Fields of the synchronised bundle
    assign strobe_low = !pin_sync[22];
    assign oe_low = !pin_sync[21];
    assign ext_present = pin_sync[20];
    assign type_sync = pin_sync[19:16];
    assign data_sync = pin_sync[15:0];

    // Command decoder
    pffp_cmd_decode #(
        .DUAL_CTRL(DUAL_CTRL)
    ) u_decode (
        .dec(dec.decoder)
    );
    assign dec.cmd_word = cmd_reg;

    // Register steering of the latched word
    assign is_cmd = (latched_type == PFFP_TYPE_CMD);
    assign is_addr_lo = (latched_type == PFFP_TYPE_ADDR_LO);
    assign is_addr_hi = (latched_type == PFFP_TYPE_ADDR_HI);
    assign is_data = (latched_type == PFFP_TYPE_DATA);
    // Unknown commands finish a data handshake without touching flash
    assign data_has_op = is_data && (dec.op != PFFP_OP_NONE);

    // Next state of the handshake sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            // Hold ready off the pin until the clock choice is made
            PFFP_ST_INIT:
            begin
                if (init_count == PFFP_INIT_CYCLES)
                begin
                    next_state = PFFP_ST_IDLE;
                end
            end
            // Wait for the strobe while ready is high
            PFFP_ST_IDLE:
            begin
                if (strobe_low)
                begin
                    next_state = PFFP_ST_DISPATCH;
                end
            end
            // Steer the latched word
            PFFP_ST_DISPATCH:
            begin
                if (is_cmd && page_pending)
                begin
                    next_state = PFFP_ST_FLUSH;
                end
                else if (data_has_op)
                begin
                    next_state = PFFP_ST_EXEC;
                end
                else
                begin
                    next_state = PFFP_ST_WAIT_STROBE_HIGH;
                end
            end
            // Previous page flushed before the new command is taken
            PFFP_ST_FLUSH:
            begin
                if (flash_ack_in)
                begin
                    next_state = PFFP_ST_WAIT_STROBE_HIGH;
                end
            end
            // Operation running in flash
            PFFP_ST_EXEC:
            begin
                if (flash_ack_in)
                begin
                    next_state = dec.reads_back ? PFFP_ST_WAIT_OE_LOW : PFFP_ST_WAIT_STROBE_HIGH;
                end
            end
            // Read: wait for the programmer to release the bus
            PFFP_ST_WAIT_OE_LOW:
            begin
                if (oe_low)
                begin
                    next_state = PFFP_ST_DRIVE;
                end
            end
            // Bus now driven, indication follows one cycle later
            PFFP_ST_DRIVE:
            begin
                next_state = PFFP_ST_WAIT_OE_HIGH;
            end
            PFFP_ST_WAIT_OE_HIGH:
            begin
                if (!oe_low)
                begin
                    next_state = PFFP_ST_WAIT_STROBE_HIGH;
                end
            end
            // Work done; end only once the strobe is back high
            PFFP_ST_WAIT_STROBE_HIGH:
            begin
                if (!strobe_low)
                begin
                    next_state = PFFP_ST_IDLE;
                end
            end
            default:
            begin
                next_state = PFFP_ST_INIT;
            end
        endcase
    end

    // State register and start-up counter
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state <= PFFP_ST_INIT;
            init_count <= '0;
        end
        else
        begin
            state <= next_state;
            init_count <= (state == PFFP_ST_INIT) ? init_count + 4'h1 : init_count;
        end
    end

    // Clock choice made once, ahead of any ready drop; absent clock leaves the RC source
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            clk_ext <= 1'b0;
            pins_active <= 1'b0;
        end
        else if (state == PFFP_ST_INIT && init_count == PFFP_INIT_CYCLES)
        begin
            clk_ext <= ext_present;
            pins_active <= 1'b1;
        end
    end

    // Latch of type and data when the strobe is seen low
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            latched_type <= '1;
            latched_data <= PFFP_DATA_RESET;
        end
        else if (state == PFFP_ST_IDLE && strobe_low)
        begin
            latched_type <= type_sync;
            latched_data <= data_sync;
        end
    end

    // Ready falls with the latch and rises when strobe is back high
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ready <= 1'b1;
        end
        else if (state == PFFP_ST_IDLE && strobe_low)
        begin
            ready <= 1'b0;
        end
        else if (state == PFFP_ST_WAIT_STROBE_HIGH && !strobe_low)
        begin
            ready <= 1'b1;
        end
    end

    // Command register; a flush ahead of it delays the store
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cmd_reg <= PFFP_CMD_RESET;
        end
        else if ((state == PFFP_ST_DISPATCH && is_cmd && !page_pending) ||
                 (state == PFFP_ST_FLUSH && flash_ack_in))
        begin
            cmd_reg <= latched_data;
        end
    end

    // Address halves, and the step after each read or page-write data word
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            addr_reg <= ADDR_W'(PFFP_ADDR_RESET);
        end
        else if (state == PFFP_ST_DISPATCH && is_addr_lo)
        begin
            addr_reg[15:0] <= latched_data;
        end
        else if (state == PFFP_ST_DISPATCH && is_addr_hi)
        begin
            addr_reg[ADDR_W-1:16] <= (ADDR_W-16)'(latched_data);
        end
        else if (state == PFFP_ST_EXEC && flash_ack_in && dec.auto_inc)
        begin
            addr_reg <= addr_reg + ADDR_W'(PFFP_ADDR_STEP);
        end
    end

    // Load buffer bookkeeping: filled by page writes, emptied by a flush
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            page_pending <= 1'b0;
        end
        else if (state == PFFP_ST_EXEC && flash_ack_in && dec.page_write)
        begin
            page_pending <= 1'b1;
        end
        else if (state == PFFP_ST_FLUSH && flash_ack_in)
        begin
            page_pending <= 1'b0;
        end
    end

    // Flash request held until the flash side acknowledges it
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            req <= 1'b0;
            req_op <= PFFP_OP_NONE;
            wdata <= PFFP_DATA_RESET;
        end
        else if (state == PFFP_ST_DISPATCH && is_cmd && page_pending)
        begin
            req <= 1'b1;
            req_op <= PFFP_OP_FLUSH;
        end
        else if (state == PFFP_ST_DISPATCH && data_has_op)
        begin
            req <= 1'b1;
            req_op <= dec.op;
            wdata <= latched_data;
        end
        else if (flash_ack_in)
        begin
            req <= 1'b0;
        end
    end

    // Read word captured with the acknowledge
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            read_data <= PFFP_DATA_RESET;
        end
        else if (state == PFFP_ST_EXEC && flash_ack_in && dec.reads_back)
        begin
            read_data <= flash_rdata_in;
        end
    end

    // Bus drive first, indication after; both released together so it never lies
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            bus_drive <= 1'b0;
            bus_valid_n <= 1'b1;
        end
        else if (state == PFFP_ST_WAIT_OE_LOW && oe_low)
        begin
            bus_drive <= 1'b1;
        end
        else if (state == PFFP_ST_DRIVE)
        begin
            bus_valid_n <= 1'b0;
        end
        else if (state == PFFP_ST_WAIT_OE_HIGH && !oe_low)
        begin
            bus_drive <= 1'b0;
            bus_valid_n <= 1'b1;
        end
    end

    // Pin outputs
    assign data_out = read_data;
    assign data_oe_out = bus_drive;
    assign ready_out = ready;
    assign ready_oe_out = pins_active;
    assign bus_driven_n_out = bus_valid_n;
    assign bus_driven_oe_out = pins_active;
    assign handshake_pullup_out = 1'b1;
    // Fixed for the whole session in this mode
    assign gpio_hold_input_out = 1'b1;
    assign osc_bypass_out = 1'b1;
    assign clock_select_ext_out = clk_ext;
    assign flash_req_out = req;
    assign flash_op_out = req_op;
    assign flash_addr_out = addr_reg;
    assign flash_wdata_out = wdata;
    assign command_out = cmd_reg;

endmodule : pffp_port

// >>> sim/pffp_port_monitor.sv
// Checker of the programming pins and the flash request side.
`timescale 1ns/100ps
module pffp_port_monitor
    import pffp_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic command_strobe_n_in,
    input wire logic output_enable_n_in,
    input wire logic ready_out,
    input wire logic ready_oe_out,
    input wire logic data_oe_out,
    input wire logic bus_driven_n_out,
    input wire logic osc_bypass_out,
    input wire logic clock_select_ext_out,
    input wire logic flash_req_out,
    input pffp_op_e flash_op_out,
    input wire logic [ADDR_W-1:0] flash_addr_out,
    input wire logic flash_ack_in,
    input wire logic [15:0] command_out
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);
    AST_BYPASS: assert property (osc_bypass_out) else $error("bypass lost");
    AST_FLAG: assert property (!bus_driven_n_out |-> data_oe_out) else $error("flag without drive");
    AST_ORDER: assert property ($rose(data_oe_out) |=> !bus_driven_n_out) else $error("flag late");
    // Inputs pass two flops, so the cause lies two edges back
    AST_OE: assert property ($rose(data_oe_out) |-> !$past(output_enable_n_in, 2))
        else $error("drive early");
    AST_DROP: assert property ($fell(ready_out) |-> !$past(command_strobe_n_in, 2))
        else $error("ready drop");
    AST_RISE: assert property ($rose(ready_out) |-> $past(command_strobe_n_in, 2) && !flash_req_out)
        else $error("ready rise");
    AST_CLK: assert property (ready_oe_out |=> $stable(clock_select_ext_out))
        else $error("clock moved");
    AST_STEP: assert property (flash_ack_in && flash_req_out && flash_op_out == PFFP_OP_WRITE_PAGE
        |=> flash_addr_out == $past(flash_addr_out) + 1'b1) else $error("no step");
    AST_CMD: assert property ($changed(command_out) |-> !ready_out) else $error("cmd idle");
    AST_SEL: assert property (flash_req_out |-> flash_op_out != PFFP_OP_SELECT_CTRL)
        else $error("controller select requested");
endmodule : pffp_port_monitor
bind pffp_port pffp_port_monitor #(.ADDR_W(ADDR_W)) u_pffp_port_monitor (.core_clk_in, .resetn_in,
    .command_strobe_n_in, .output_enable_n_in, .ready_out, .ready_oe_out, .data_oe_out, .bus_driven_n_out,
    .osc_bypass_out, .clock_select_ext_out, .flash_req_out, .flash_op_out, .flash_addr_out, .flash_ack_in,
    .command_out);

// >>> sim/pffp_prog_model.sv
// Programmer model driving strobe, enable, type and data pins.
`timescale 1ns/100ps
module pffp_prog_model
(
    input wire logic clk_in,
    input wire logic ready_in,
    input wire logic flag_n_in,
    input wire logic [15:0] bus_in,
    output logic strobe_n_out,
    output logic oe_n_out,
    output logic [3:0] type_out,
    output logic [15:0] data_out
);
    // Released pins sit at their pull-up level; test and enable straps stay tied high off this port
    initial
    begin
        strobe_n_out = 1'b1;
        oe_n_out = 1'b1;
        type_out = 4'hf;
        data_out = 16'hffff;
    end
    // Bounded wait on ready or the bus flag
    task wt(input bit sel, input logic v);
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(posedge clk_in);
            if ((sel ? flag_n_in : ready_in) === v)
                break;
        end
        if (i == 300)
        begin
            pffp_port_tb.fail_count++;
            pffp_port_tb.print_verdict();
        end
        #1;
    endtask : wt
    // One handshake; a read also takes the driven word
    task xfer(input logic [3:0] t, input logic [15:0] d, input bit rd, output logic [15:0] q);
        wt(0, 1'b1);
        type_out = t;
        data_out = d;
        @(posedge clk_in);
        #1;
        strobe_n_out = 1'b0;
        wt(0, 1'b0);
        // Hold two more edges: the device samples through flops
        repeat (2) @(posedge clk_in);
        #1;
        type_out = 4'hf;
        data_out = 16'hffff;
        q = 16'hffff;
        if (rd)
        begin
            oe_n_out = 1'b0;
            wt(1, 1'b0);
            q = bus_in;
            oe_n_out = 1'b1;
            wt(1, 1'b1);
        end
        strobe_n_out = 1'b1;
        wt(0, 1'b1);
    endtask : xfer
endmodule : pffp_prog_model

// >>> sim/pffp_port_tb.sv
// Testbench of the parallel flash programming port.
`timescale 1ns/100ps
module pffp_port_tb
    import pffp_pkg::*;
;
    logic clk, rstn, stb_n, oe_n, doe, rdy, roe, bdn, boe, pu, gh, ob, csel, req;
    logic ext = 1'b1; // External clock present on the first run
    logic ack = 1'b0;
    logic [3:0] typ;
    logic [15:0] din, dout, wd, cmd, q, last_wd;
    logic [31:0] addr;
    pffp_op_e op, last_op;
    logic [1:0] wcnt = 2'd0;
    int n_ack = 0, fail_count = 0, checked = 0;
    logic flushed = 1'b0;
    pffp_port #(.DUAL_CTRL(1'b0)) u_pffp_port (.core_clk_in(clk), .resetn_in(rstn), .command_strobe_n_in(stb_n),
        .output_enable_n_in(oe_n), .transfer_type_in(typ), .data_in(din), .data_out(dout), .data_oe_out(doe),
        .ready_out(rdy), .ready_oe_out(roe), .bus_driven_n_out(bdn), .bus_driven_oe_out(boe),
        .handshake_pullup_out(pu), .gpio_hold_input_out(gh), .osc_bypass_out(ob), .ext_clock_present_in(ext),
        .clock_select_ext_out(csel), .flash_req_out(req), .flash_op_out(op), .flash_addr_out(addr),
        .flash_wdata_out(wd), .flash_ack_in(ack), .flash_rdata_in(addr[15:0] ^ 16'h5a00), .command_out(cmd));
    pffp_prog_model u_pffp_prog_model (.clk_in(clk), .ready_in(rdy), .flag_n_in(bdn), .bus_in(dout),
        .strobe_n_out(stb_n), .oe_n_out(oe_n), .type_out(typ), .data_out(din));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Flash side answers three edges after a request
    always @(posedge clk)
    begin
        ack <= 1'b0;
        if (req && !ack)
        begin
            wcnt <= wcnt + 2'd1;
            if (wcnt == 2'd2)
            begin
                ack <= 1'b1;
                wcnt <= 2'd0;
                last_op <= op;
                last_wd <= wd;
                n_ack <= n_ack + 1;
                flushed <= flushed | (op == PFFP_OP_FLUSH);
            end
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task print_verdict();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // Reset with or without an external clock; pins start as inputs, then come up
    task t_reset(input logic e);
        rstn = 1'b0;
        ext = e;
        repeat (20) @(posedge clk);
        #1;
        chk("reset pins", 32'h3, {roe, boe, doe, req, csel, rdy, bdn});
        rstn = 1'b1;
        repeat (10) @(posedge clk);
        chk("pins", {3'h7, e, 4'hf}, {pu, gh, ob, csel, bdn, rdy, roe, boe});
        $display("reset test done");
    endtask : t_reset
    task t_write();
        u_pffp_prog_model.xfer(PFFP_TYPE_CMD, PFFP_CMD_WRITE_PAGE, 0, q);
        chk("cmd", PFFP_CMD_WRITE_PAGE, cmd);
        u_pffp_prog_model.xfer(PFFP_TYPE_ADDR_LO, 16'h0010, 0, q);
        u_pffp_prog_model.xfer(PFFP_TYPE_ADDR_HI, 16'h0001, 0, q);
        u_pffp_prog_model.xfer(4'h3, 16'h0077, 0, q);
        chk("addr", 32'h0001_0010, addr);
        u_pffp_prog_model.xfer(PFFP_TYPE_DATA, 16'habcd, 0, q);
        u_pffp_prog_model.xfer(PFFP_TYPE_DATA, 16'h1234, 0, q);
        chk("wdata", 32'h1234, last_wd);
        chk("addr", 32'h0001_0012, addr);
        $display("write test done");
    endtask : t_write
    task t_read();
        u_pffp_prog_model.xfer(PFFP_TYPE_CMD, PFFP_CMD_READ, 0, q);
        chk("flush", 1, flushed);
        u_pffp_prog_model.xfer(PFFP_TYPE_ADDR_LO, 16'h0040, 0, q);
        u_pffp_prog_model.xfer(PFFP_TYPE_ADDR_HI, 16'h0000, 0, q);
        u_pffp_prog_model.xfer(PFFP_TYPE_DATA, 16'hffff, 1, q);
        chk("rdata", 32'h5a40, q);
        u_pffp_prog_model.xfer(PFFP_TYPE_DATA, 16'hffff, 1, q);
        chk("rdata", 32'h5a41, q);
        $display("read test done");
    endtask : t_read
    task t_decode();
        logic [15:0] c [12] = '{16'h0011, 16'h0012, 16'h0022, 16'h0032, 16'h0042, 16'h0013, 16'h0014,
            16'h0024, 16'h0015, 16'h0034, 16'h0044, 16'h0025};
        bit rb [12] = '{1, 0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 1};
        int n0;
        for (int i = 0; i < 12; i++)
        begin
            u_pffp_prog_model.xfer(PFFP_TYPE_CMD, c[i], 0, q);
            u_pffp_prog_model.xfer(PFFP_TYPE_DATA, 16'h0003, rb[i], q);
            chk("op", i + 1, last_op);
        end
        u_pffp_prog_model.xfer(PFFP_TYPE_CMD, PFFP_CMD_SELECT_FLASH_CONTROLLER, 0, q);
        n0 = n_ack;
        u_pffp_prog_model.xfer(PFFP_TYPE_DATA, 16'h0001, 0, q);
        chk("no request", n0, n_ack);
        $display("decode test done");
    endtask : t_decode
    initial
    begin
        t_reset(1'b1);
        t_write();
        t_read();
        t_decode();
        // Second release with no external clock must keep the RC source
        t_reset(1'b0);
        print_verdict();
    end
endmodule : pffp_port_tb
